// file: rtl/hpcp_defs.svh
// Constants for the host port and configuration pin block.
// Assumes inclusion by the package and the principal module only.
`ifndef HPCP_DEFS_SVH
`define HPCP_DEFS_SVH

`define HPCP_DATA_W        16
`define HPCP_ADDR_W        16
`define HPCP_ADDR_BIDIR_W  4
`define HPCP_TA_W          5
`define HPCP_MODE_W        8
`define HPCP_REG_SEL_W     2
// Register select codes
`define HPCP_REG_CTRL      2'h0
`define HPCP_REG_TERM      2'h1
`define HPCP_REG_STAT      2'h2
`define HPCP_REG_MADDR     2'h3
// Control register fields
`define HPCP_CTRL_ROLE     8
`define HPCP_CTRL_START    9
`define HPCP_CTRL_WRITE    10
`define HPCP_CTRL_CNT_LSB  11
`define HPCP_CTRL_CNT_W    4
`define HPCP_CTRL_MODE_MSB 7
// Reset values
`define HPCP_MODE_RST      8'h00
`define HPCP_ROLE_RST      1'h0
// Timing
`define HPCP_CLK_NS        40
`define HPCP_RST_MIN_NS    500
`define HPCP_STROBE_CYC    2'h2
`define HPCP_STRAP_CYC     2'h3

`endif

// file: rtl/hpcp_host_port.sv
// Host parallel port, strapped configuration and external RAM strobes.
// Assumes one 25 MHz clock; host pins arrive asynchronously; pins are
// resolved outside from the output enables.
//
// Behaviour
// - Data bus is 16 bits, bit 0 least and bit 15 most significant.
// - Five terminal address pins are captured at master reset.
// - Captured terminal address is readable through its own register.
// - Parity pin is odd parity over the five address bits.
// - Register read only while read strobe and chip select are low; device drives data.
// - Register write only while write strobe and chip select are low; data stored.
// - Address lines driven only while address-drive permit is high.
// - Role select high means bus controller, low means remote terminal.
// - Lock low lets control role bit override the role pin; lock high pin governs.
// - Lock high blocks changes to address, role and eight mode bits.
// - External abort low aborts any memory access in progress; register reads and writes proceed.
// - Master reset returns all state and registers to reset.
// - RAM select input passes through to RAM select output.
// - Device asserts RAM select output for its own memory accesses.
// - Load strobe only after grant, one pulse per word.
// - Host and device both use store strobe to write RAM.
// - Store strobe only after grant, one pulse per word.
// - Address bus 16 bits; low four bidirectional, rest outputs.
// - Address and data buses released when unused.
`default_nettype none
`include "hpcp_defs.svh"

module hpcp_host_port
  import hpcp_pkg::*;
(
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  input  wire logic [`HPCP_DATA_W-1:0]       i_data,
  output logic      [`HPCP_DATA_W-1:0]       o_data,
  output logic                               o_data_oe,
  input  wire logic [`HPCP_ADDR_BIDIR_W-1:0] i_addr_low,
  output logic      [`HPCP_ADDR_W-1:0]       o_addr,
  output logic                               o_addr_oe,
  input  wire logic                          i_read_n,
  input  wire logic                          i_write_n,
  input  wire logic                          i_chip_select_n,
  input  wire logic                          i_address_drive_permit,
  input  wire logic [`HPCP_TA_W-1:0]         i_term_addr_bits,
  input  wire logic                          i_term_addr_parity,
  input  wire logic                          i_role_select_pin,
  input  wire logic                          i_lock,
  input  wire logic                          i_external_abort_n,
  input  wire logic                          i_ram_select_in_n,
  input  wire logic                          i_memory_grant,
  input  wire logic                          i_mem_idle,
  output logic                               o_ram_select_out_n,
  output logic                               o_ram_load_strobe_n,
  output logic                               o_ram_store_strobe_n,
  output logic                               o_memory_request,
  output logic                               o_bus_controller_role,
  output logic      [`HPCP_MODE_W-1:0]       o_operation_mode_bits,
  output logic      [`HPCP_TA_W-1:0]         o_term_addr,
  output logic                               o_term_addr_parity_ok,
  output logic      [`HPCP_DATA_W-1:0]       o_mem_read_data,
  output logic                               o_mem_read_valid
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int SYNC_W = `HPCP_DATA_W + `HPCP_ADDR_BIDIR_W + `HPCP_TA_W + 9;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync_d;
  logic [1:0]        strap_cnt_q;
  logic [1:0]        strap_cnt_d;

  assign sync_d = {i_data, i_addr_low, i_term_addr_bits, i_term_addr_parity,
                   i_read_n, i_write_n, i_chip_select_n, i_address_drive_permit,
                   i_role_select_pin, i_lock, i_external_abort_n, i_memory_grant};

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
    end
  end

  logic [`HPCP_DATA_W-1:0] s_data;
  logic [`HPCP_TA_W-1:0]   s_ta;
  logic [`HPCP_ADDR_BIDIR_W-1:0] s_addr_low;
  logic s_par, s_rd_n, s_wr_n, s_cs_n, s_permit, s_role, s_lock, s_abort_n, s_grant;
  assign s_data    = sync2_q[SYNC_W-1 -: `HPCP_DATA_W];
  assign s_ta      = sync2_q[`HPCP_TA_W+8:9];
  assign s_addr_low = sync2_q[`HPCP_TA_W+9 +: `HPCP_ADDR_BIDIR_W];
  assign s_par     = sync2_q[8];
  assign s_rd_n    = sync2_q[7];
  assign s_wr_n    = sync2_q[6];
  assign s_cs_n    = sync2_q[5];
  assign s_permit  = sync2_q[4];
  assign s_role    = sync2_q[3];
  assign s_lock    = sync2_q[2];
  assign s_abort_n = sync2_q[1];
  assign s_grant   = sync2_q[0];

  // Odd parity check over address and parity bit
  function automatic logic hpcp_odd_ok(input logic [`HPCP_TA_W-1:0] ta, input logic p);
    hpcp_odd_ok = ^{ta, p};
  endfunction : hpcp_odd_ok

  // ==========================================================================
  // Host registers
  // ==========================================================================
  logic [`HPCP_TA_W-1:0]   ta_q, ta_d;
  logic [`HPCP_MODE_W-1:0] mode_q, mode_d;
  logic                    role_q, role_d;
  logic                    wr_seen_q, wr_seen_d;
  logic [`HPCP_ADDR_W-1:0] maddr_q, maddr_d;
  logic [`HPCP_DATA_W-1:0] wdata_q, wdata_d;
  logic [`HPCP_CTRL_CNT_W-1:0] cnt_q, cnt_d;
  logic                    dir_wr_q, dir_wr_d;
  logic                    start;
  logic                    reg_wr;
  logic [`HPCP_REG_SEL_W-1:0] sel;
  logic                    busy;

  assign sel    = s_addr_low[`HPCP_REG_SEL_W-1:0];
  assign reg_wr = !s_wr_n && !s_cs_n && !wr_seen_q;

  always_comb begin
    ta_d      = ta_q;
    mode_d    = mode_q;
    role_d    = role_q;
    maddr_d   = maddr_q;
    wdata_d   = wdata_q;
    cnt_d     = cnt_q;
    dir_wr_d  = dir_wr_q;
    start     = 1'b0;
    wr_seen_d = !s_wr_n && !s_cs_n;
    if (strap_cnt_q != `HPCP_STRAP_CYC) begin
      ta_d = s_ta;
    end
    if (reg_wr) begin
      unique case (sel)
        `HPCP_REG_CTRL: begin
          if (!s_lock) begin
            mode_d = s_data[`HPCP_CTRL_MODE_MSB:0];
            role_d = s_data[`HPCP_CTRL_ROLE];
          end
          cnt_d = s_data[`HPCP_CTRL_CNT_LSB +: `HPCP_CTRL_CNT_W];
          if (s_data[`HPCP_CTRL_START] && !busy) begin
            start    = 1'b1;
            dir_wr_d = s_data[`HPCP_CTRL_WRITE];
          end
        end
        `HPCP_REG_TERM: begin
          if (!s_lock) begin
            ta_d = s_data[`HPCP_TA_W-1:0];
          end
        end
        `HPCP_REG_STAT: begin
          wdata_d = s_data;
        end
        `HPCP_REG_MADDR: begin
          maddr_d = s_data;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ta_q         <= '0;
      mode_q       <= `HPCP_MODE_RST;
      role_q       <= `HPCP_ROLE_RST;
      wr_seen_q    <= 1'b0;
      maddr_q      <= '0;
      wdata_q      <= '0;
      cnt_q        <= '0;
      dir_wr_q     <= 1'b0;
      strap_cnt_q  <= '0;
    end else begin
      ta_q         <= ta_d;
      mode_q       <= mode_d;
      role_q       <= role_d;
      wr_seen_q    <= wr_seen_d;
      maddr_q      <= maddr_d;
      wdata_q      <= wdata_d;
      cnt_q        <= cnt_d;
      dir_wr_q     <= dir_wr_d;
      strap_cnt_q  <= strap_cnt_d;
    end
  end

  // Strap follows the pins until the synchroniser has carried their levels through
  assign strap_cnt_d = (strap_cnt_q == `HPCP_STRAP_CYC) ? strap_cnt_q : strap_cnt_q + 2'h1;

  // Role: pin governs under lock, control bit otherwise
  assign o_bus_controller_role = s_lock ? s_role : role_q;
  assign o_operation_mode_bits = mode_q;
  assign o_term_addr           = ta_q;
  assign o_term_addr_parity_ok = hpcp_odd_ok(ta_q, s_par);

  // ==========================================================================
  // Memory access sequencer
  // ==========================================================================
  hpcp_state_type state_q, state_d;
  logic [1:0]              tick_q, tick_d;
  logic [`HPCP_DATA_W-1:0] rdata_q, rdata_d;
  logic                    rvalid_q, rvalid_d;
  logic [`HPCP_ADDR_W-1:0]     mptr_q, mptr_d;
  logic [`HPCP_CTRL_CNT_W-1:0] left_q, left_d;

  assign busy = (state_q != HPCP_IDLE);

  always_comb begin
    state_d  = state_q;
    tick_d   = tick_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    unique case (state_q)
      HPCP_IDLE: begin
        if (start && i_mem_idle) begin
          state_d = HPCP_REQ;
        end
      end
      HPCP_REQ: begin
        tick_d = '0;
        if (s_grant && s_permit) begin
          state_d = HPCP_STROBE;
        end
      end
      HPCP_STROBE: begin
        tick_d = tick_q + 2'h1;
        if (tick_q == `HPCP_STROBE_CYC - 2'h1) begin
          state_d = HPCP_GAP;
          tick_d  = '0;
        end
      end
      HPCP_GAP: begin
        // Read word leaves the synchroniser one cycle after the strobe ends
        tick_d = 2'h1;
        if (tick_q == '0 && !dir_wr_q) begin
          rdata_d  = s_data;
          rvalid_d = 1'b1;
        end
        // One strobe pulse per word
        if (left_q == '0) begin
          state_d = HPCP_IDLE;
        end else if (s_grant && s_permit) begin
          state_d = HPCP_STROBE;
          tick_d  = '0;
        end
      end
      default: state_d = HPCP_IDLE;
    endcase
    if (!s_abort_n) begin
      state_d = HPCP_IDLE;
    end
  end

  // Word count and address advance kept in the sequencer flops
  always_comb begin
    mptr_d = mptr_q;
    left_d = left_q;
    if (start) begin
      mptr_d = maddr_q;
      left_d = cnt_q;
    end else if (state_q == HPCP_GAP && state_d == HPCP_STROBE) begin
      mptr_d = mptr_q + `HPCP_ADDR_W'(1);
      left_d = left_q - `HPCP_CTRL_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q  <= HPCP_IDLE;
      tick_q   <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      mptr_q   <= '0;
      left_q   <= '0;
    end else begin
      state_q  <= state_d;
      tick_q   <= tick_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      mptr_q   <= mptr_d;
      left_q   <= left_d;
    end
  end

  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  logic strobing, owning;
  assign strobing = (state_q == HPCP_STROBE);
  assign owning   = (state_q == HPCP_STROBE || state_q == HPCP_GAP) && s_permit;

  assign o_memory_request     = (state_q != HPCP_IDLE);
  assign o_ram_select_out_n   = i_ram_select_in_n && !strobing;
  assign o_ram_load_strobe_n  = !(strobing && !dir_wr_q);
  assign o_ram_store_strobe_n = !(strobing && dir_wr_q);
  assign o_addr               = mptr_q;
  assign o_addr_oe            = owning && s_grant;

  always_comb begin
    o_data    = '0;
    o_data_oe = 1'b0;
    if (!s_rd_n && !s_cs_n) begin
      o_data_oe = 1'b1;
      unique case (sel)
        `HPCP_REG_CTRL:  o_data = {1'b0, left_q, dir_wr_q, busy, role_q, mode_q};
        `HPCP_REG_TERM:  o_data = {10'h000, s_par, ta_q};
        `HPCP_REG_STAT:  o_data = rdata_q;
        `HPCP_REG_MADDR: o_data = maddr_q;
      endcase
    end else if (strobing && dir_wr_q && s_grant) begin
      o_data    = wdata_q;
      o_data_oe = 1'b1;
    end
  end

  assign o_mem_read_data  = rdata_q;
  assign o_mem_read_valid = rvalid_q;

endmodule : hpcp_host_port
`default_nettype wire

// file: rtl/hpcp_pkg.sv
// Types for the host port and configuration pin block.
// Assumes hpcp_defs.svh is on the include path.
`default_nettype none
`include "hpcp_defs.svh"
package hpcp_pkg;
  typedef struct packed {
    logic                     req;
    logic [`HPCP_ADDR_W-1:0] addr;
    logic [`HPCP_DATA_W-1:0] data;
  } hpcp_mem_type;

  typedef struct packed {
    logic                     rd_n;
    logic                     wr_n;
    logic                     cs_n;
    logic [`HPCP_REG_SEL_W-1:0] sel;
  } hpcp_host_type;

  typedef enum logic [3:0] {
    HPCP_IDLE   = 4'h1,
    HPCP_REQ    = 4'h2,
    HPCP_STROBE = 4'h4,
    HPCP_GAP    = 4'h8
  } hpcp_state_type;
endpackage : hpcp_pkg
`default_nettype wire

// file: verif/hpcp_host_port_properties.sv
// Checker of the host port block.
// Assumes binding to hpcp_host_port; sees its ports only.
`default_nettype none
module hpcp_host_port_props (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_chip_select_n,
  input wire logic i_address_drive_permit,
  input wire logic i_role_select_pin,
  input wire logic i_lock,
  input wire logic i_external_abort_n,
  input wire logic i_ram_select_in_n,
  input wire logic i_memory_grant,
  input wire logic o_data_oe,
  input wire logic o_addr_oe,
  input wire logic o_ram_select_out_n,
  input wire logic o_ram_load_strobe_n,
  input wire logic o_ram_store_strobe_n,
  input wire logic o_memory_request,
  input wire logic o_bus_controller_role
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ==========
  // Port relations
  sel_pass_a: assert property (!o_memory_request |-> o_ram_select_out_n == i_ram_select_in_n)
    else $error("ram select not passed through");
  load_grant_a: assert property (!o_ram_load_strobe_n |-> i_memory_grant)
    else $error("load strobe without grant");
  store_grant_a: assert property (!o_ram_store_strobe_n |-> i_memory_grant)
    else $error("store strobe without grant");
  load_width_a: assert property ($fell(o_ram_load_strobe_n) |-> ##1 !o_ram_load_strobe_n ##1 o_ram_load_strobe_n)
    else $error("load strobe pulse width wrong");
  sel_strobe_a: assert property (!(o_ram_load_strobe_n && o_ram_store_strobe_n) |-> !o_ram_select_out_n)
    else $error("ram select missing during access");
  addr_permit_a: assert property (o_addr_oe |-> i_address_drive_permit && o_memory_request)
    else $error("address driven without permit");
  data_release_a: assert property ((i_chip_select_n && !o_memory_request) [*4] |-> !o_data_oe)
    else $error("data bus driven while idle");
  abort_idle_a: assert property (!i_external_abort_n [*4] |-> !o_memory_request)
    else $error("access not aborted");
  role_pin_a: assert property ((i_lock && $stable(i_role_select_pin)) [*5] |->
    o_bus_controller_role == i_role_select_pin)
    else $error("role does not follow pin under lock");
endmodule : hpcp_host_port_props

bind hpcp_host_port hpcp_host_port_props i_props (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_chip_select_n(i_chip_select_n), .i_address_drive_permit(i_address_drive_permit),
  .i_role_select_pin(i_role_select_pin), .i_lock(i_lock),
  .i_external_abort_n(i_external_abort_n), .i_ram_select_in_n(i_ram_select_in_n),
  .i_memory_grant(i_memory_grant), .o_data_oe(o_data_oe), .o_addr_oe(o_addr_oe),
  .o_ram_select_out_n(o_ram_select_out_n), .o_ram_load_strobe_n(o_ram_load_strobe_n),
  .o_ram_store_strobe_n(o_ram_store_strobe_n), .o_memory_request(o_memory_request),
  .o_bus_controller_role(o_bus_controller_role));
`default_nettype wire

// file: verif/hpcp_ram_model.sv
// Grant source and external RAM on the host side.
// Assumes a 16-word RAM decoded from the low address bits.
`default_nettype none
module hpcp_ram_model (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_request,
  input  wire logic        i_slow,
  input  wire logic        i_select_n,
  input  wire logic        i_load_n,
  input  wire logic        i_store_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_data,
  output logic             o_grant,
  output logic      [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0;
  logic [2:0]  wait_q;
  // ==========
  // Grant, memory and released data lines
  initial for (int k = 0; k < 16; k++) mem[k] = 16'hc300 | 16'(k);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q  <= 3'h0;
      o_grant <= 1'b0;
    end else begin
      wait_q  <= i_request ? wait_q + 3'h1 : 3'h0;
      o_grant <= i_request && (o_grant || !i_slow || wait_q == 3'h5);
    end
  end
  always @(posedge i_clock) begin
    last_q <= o_data;
    if (!i_select_n && !i_store_n) mem[i_addr[3:0]] <= i_data;
  end
  assign o_data = (!i_select_n && !i_load_n) ? mem[i_addr[3:0]] : ~last_q;
endmodule : hpcp_ram_model
`default_nettype wire

// file: verif/tb.sv
// Bench of the host port block, acting as host and neighbour device.
// Assumes the package, checker and RAM model are compiled first.
`default_nettype none
module tb
  import hpcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          i_clock = 1'b0;
  logic          i_rst_n = 1'b0;
  hpcp_host_type host = '{1'b1, 1'b1, 1'b1, 2'h0};
  logic [15:0]   hdata = 16'h0, bus, ram_q, o_data, o_addr, mem_rd;
  logic [4:0]    ta = 5'h0, ta_seen;
  logic [7:0]    mode;
  logic          par = 1'b1, permit = 1'b1, role_pin = 1'b0, lock = 1'b1, abort_n = 1'b1;
  logic          sel_in_n = 1'b1, slow = 1'b0, grant, data_oe, addr_oe, sel_out_n;
  logic          load_n, store_n, req, role, par_ok, rd_vld;
  integer        seed = 32'h9166591f;
  int            fails = 0, samples_checked = 0, cycles = 0;
  logic [15:0]   exp_q[$];
  always #20 i_clock = ~i_clock;
  assign bus = data_oe ? o_data : (!host.wr_n ? hdata : ram_q);
  hpcp_host_port i_hpcp_host_port (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_data(bus),
    .o_data(o_data), .o_data_oe(data_oe), .i_addr_low({2'h0, host.sel}), .o_addr(o_addr),
    .o_addr_oe(addr_oe), .i_read_n(host.rd_n), .i_write_n(host.wr_n),
    .i_chip_select_n(host.cs_n), .i_address_drive_permit(permit), .i_term_addr_bits(ta),
    .i_term_addr_parity(par), .i_role_select_pin(role_pin), .i_lock(lock),
    .i_external_abort_n(abort_n), .i_ram_select_in_n(sel_in_n), .i_memory_grant(grant),
    .i_mem_idle(1'b1), .o_ram_select_out_n(sel_out_n), .o_ram_load_strobe_n(load_n),
    .o_ram_store_strobe_n(store_n), .o_memory_request(req), .o_bus_controller_role(role),
    .o_operation_mode_bits(mode), .o_term_addr(ta_seen), .o_term_addr_parity_ok(par_ok),
    .o_mem_read_data(mem_rd), .o_mem_read_valid(rd_vld));
  hpcp_ram_model i_hpcp_ram_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_request(req),
    .i_slow(slow), .i_select_n(sel_out_n), .i_load_n(load_n), .i_store_n(store_n),
    .i_addr(o_addr), .i_data(bus), .o_grant(grant), .o_data(ram_q));
  // ==========
  // Shared tasks
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic reg_wr(input logic [1:0] s, input logic [15:0] v);
    @(posedge i_clock);
    host  <= '{1'b1, 1'b0, 1'b0, s};
    hdata <= v;
    repeat (4) @(posedge i_clock);
    host  <= '{1'b1, 1'b1, 1'b1, s};
    repeat (4) @(posedge i_clock);
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] s, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_clock);
    host <= '{1'b0, 1'b1, 1'b0, s};
    repeat (4) @(posedge i_clock);
    check("read data", e, o_data & m);
    check("read drive", 16'h1, {15'h0, data_oe});
    host <= '{1'b1, 1'b1, 1'b1, s};
    repeat (4) @(posedge i_clock);
  endtask : reg_rd
  task automatic wait_idle;
    for (int k = 0; k < 300 && req !== 1'b0; k++) @(posedge i_clock);
    check("idle", 16'h0, {15'h0, req});
  endtask : wait_idle
  task automatic print_verdict;
    check("queue left", 16'h0, 16'(exp_q.size()));
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ==========
  // Read word monitor and time limit
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (rd_vld === 1'b1) begin
      if (exp_q.size() == 0) check("spare word", 16'h0, 16'hffff);
      else check("ram word", exp_q.pop_front(), mem_rd);
    end
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ==========
  // Main sequence
  initial begin
    logic [4:0]  t;
    logic [15:0] d;
    for (int r = 0; r < 2; r++) begin
      t = 5'($random(seed));
      i_rst_n <= 1'b0;
      ta  <= t;
      par <= (~^t) ^ r[0];
      repeat (16) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (6) @(posedge i_clock);
      ta <= ~t;
      check("term addr", {11'h0, t}, {11'h0, ta_seen});
      check("parity ok", {15'h0, ~r[0]}, {15'h0, par_ok});
      reg_rd(2'h1, 16'h001f, {11'h0, t});
      check("mode reset", 16'h0, {8'h0, mode});
      if (r == 0) begin
        for (int p = 0; p < 2; p++) begin
          role_pin <= p[0];
          repeat (6) @(posedge i_clock);
          check("role pin", {15'h0, p[0]}, {15'h0, role});
        end
        lock <= 1'b0;
        reg_wr(2'h0, 16'h005a);
        check("role ctrl", 16'h0, {15'h0, role});
        check("mode set", 16'h005a, {8'h0, mode});
        lock <= 1'b1;
        reg_wr(2'h0, 16'h0133);
        reg_wr(2'h1, {11'h0, ~t});
        check("mode locked", 16'h005a, {8'h0, mode});
        check("term locked", {11'h0, t}, {11'h0, ta_seen});
        check("role locked", 16'h1, {15'h0, role});
        lock <= 1'b0;
        slow <= 1'b1;
        reg_wr(2'h3, 16'h000e);
        reg_wr(2'h0, 16'h0800);
        exp_q.push_back(16'hc30e);
        exp_q.push_back(16'hc30f);
        reg_wr(2'h0, 16'h0a00);
        wait_idle();
        d = 16'($random(seed));
        slow <= 1'b0;
        reg_wr(2'h2, d);
        reg_wr(2'h3, 16'h0003);
        reg_wr(2'h0, 16'h0000);
        reg_wr(2'h0, 16'h0600);
        wait_idle();
        permit <= 1'b0;
        exp_q.push_back(d);
        reg_wr(2'h0, 16'h0200);
        repeat (10) @(posedge i_clock);
        check("permit hold", 16'h1, {15'h0, load_n & ~addr_oe});
        permit <= 1'b1;
        wait_idle();
        permit <= 1'b0;
        reg_wr(2'h0, 16'h02a5);
        check("pending", 16'h1, {15'h0, req});
        abort_n <= 1'b0;
        repeat (5) @(posedge i_clock);
        check("abort", 16'h0, {15'h0, req});
        abort_n <= 1'b1;
        permit <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          sel_in_n <= k[0];
          @(negedge i_clock);
          check("ram select", {15'h0, k[0]}, {15'h0, sel_out_n});
          @(posedge i_clock);
        end
      end
    end
    print_verdict();
  end
endmodule : tb
`default_nettype wire
